// [src/lock_irq_pkg.sv]
`default_nettype none

package lock_irq_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_LOOPS  = 4;
	localparam int NUM_INPUTS = 4;
	localparam int ADDR_W     = 12;
	localparam int IDX_W      = 10;
	localparam int DELAY_W    = 29;
	localparam int TIMER_W    = 37;
	localparam int MEAS_W     = 24;

	// ----------------------------------------------------------------
	// Register indexes; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_REF_LIVE    = 10'h00C;
	localparam logic [IDX_W-1:0] IDX_IN_LIVE     = 10'h00D;
	localparam logic [IDX_W-1:0] IDX_LOOP_LIVE   = 10'h00E;
	localparam logic [IDX_W-1:0] IDX_REF_STICKY  = 10'h011;
	localparam logic [IDX_W-1:0] IDX_IN_STICKY   = 10'h012;
	localparam logic [IDX_W-1:0] IDX_LOOP_STICKY = 10'h013;
	localparam logic [IDX_W-1:0] IDX_REF_MASK    = 10'h017;
	localparam logic [IDX_W-1:0] IDX_IN_MASK     = 10'h018;
	localparam logic [IDX_W-1:0] IDX_LOOP_MASK   = 10'h019;
	localparam logic [IDX_W-1:0] IDX_SET_THR     = 10'h09E;
	localparam logic [IDX_W-1:0] IDX_CLR_THR     = 10'h0A0;
	localparam logic [IDX_W-1:0] IDX_TIMER_EN    = 10'h0A2;
	localparam logic [IDX_W-1:0] IDX_DELAY0      = 10'h0A4;
	localparam logic [IDX_W-1:0] IDX_FAST_EN     = 10'h0A8;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int REF_BIT  = 1;
	localparam int HIGH_LSB = 4;
	localparam int THR_W    = 4;
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam logic [15:0] THR_RST    = 16'h0000;
	localparam logic [3:0]  EN_RST     = 4'h0;
	localparam logic [28:0] DELAY_RST  = 29'h0000000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MIN_DELAY_NS  = 4;
	localparam int MIN_DELAY_CYC =
		(MIN_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DELAY_UNIT_SHIFT = 8;
	localparam logic [MEAS_W-1:0] WINDOW_DEFAULT = 24'h989680;

	// Threshold code to frequency error in tenths of a ppm.
	function automatic logic [MEAS_W-1:0] ppm_tenths(
		input logic [THR_W-1:0] code
	);
		unique case (code)
			4'h0:    ppm_tenths = 24'h000001;
			4'h1:    ppm_tenths = 24'h000003;
			4'h2:    ppm_tenths = 24'h00000A;
			4'h3:    ppm_tenths = 24'h00001E;
			4'h4:    ppm_tenths = 24'h000064;
			4'h5:    ppm_tenths = 24'h00012C;
			4'h6:    ppm_tenths = 24'h0003E8;
			4'h7:    ppm_tenths = 24'h000BB8;
			4'h8:    ppm_tenths = 24'h002710;
			4'h9:    ppm_tenths = 24'h007530;
			default: ppm_tenths = 24'h0186A0;
		endcase
	endfunction

endpackage

`default_nettype wire

// [src/lock_loss_and_irq_monitor.sv]
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module lock_loss_and_irq_monitor
	import lock_irq_pkg::*;
#(
	parameter logic [MEAS_W-1:0] WINDOW_EDGES = WINDOW_DEFAULT
) (
	// Clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_arst_n,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0]     i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output var  logic [31:0]           o_avs_readdata,
	output var  logic                  o_avs_waitrequest,
	// Loop side
	input  wire logic [NUM_LOOPS-1:0]  i_loop_ref_edge,
	input  wire logic [NUM_LOOPS-1:0]  i_loop_fb_edge,
	input  wire logic [NUM_LOOPS-1:0]  i_loop_holdover,
	output var  logic [NUM_LOOPS-1:0]  o_loop_unlocked_pin,
	output var  logic [NUM_LOOPS-1:0]  o_fast_acquire,
	// Input monitors
	input  wire logic [NUM_INPUTS-1:0] i_signal_missing,
	input  wire logic [NUM_INPUTS-1:0] i_freq_out_of_range,
	input  wire logic                  i_crystal_missing,
	// Interrupt
	output var  logic                  o_irq_n_pin
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;
	// Both stages clear at once; release ripples through in two edges.

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	function automatic logic [31:0] lanes(input logic [3:0] be);
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wdata,
		input logic [3:0]  be
	);
		merge = (old & ~lanes(be)) | (wdata & lanes(be));
	endfunction

	logic [IDX_W-1:0] idx;
	logic             wr_fire;
	logic [31:0]      zero_wr;

	// The low two address bits are ignored; each register is one word.
	assign idx     = i_avs_address[ADDR_W-1:2];
	assign wr_fire = i_avs_write & ~o_avs_waitrequest;
	// Bits written with zero on enabled lanes.
	assign zero_wr = lanes(i_avs_byteenable) & ~i_avs_writedata;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic                  ref_mask;
	logic [7:0]            in_mask;
	logic [7:0]            loop_mask;
	logic [15:0]           set_thr;
	logic [15:0]           clr_thr;
	logic [NUM_LOOPS-1:0]  timer_en;
	logic [NUM_LOOPS-1:0]  fast_en;
	logic [DELAY_W-1:0]    clr_delay [NUM_LOOPS];

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_mask  <= MASK_RST[REF_BIT];
			in_mask   <= MASK_RST;
			loop_mask <= MASK_RST;
			set_thr   <= THR_RST;
			clr_thr   <= THR_RST;
			timer_en  <= EN_RST;
			fast_en   <= EN_RST;
			for (int l = 0; l < NUM_LOOPS; l++) begin
				clr_delay[l] <= DELAY_RST;
			end
		end else if (wr_fire) begin
			unique case (idx)
				IDX_REF_MASK: begin
					if (i_avs_byteenable[0]) begin
						ref_mask <= i_avs_writedata[REF_BIT];
					end
				end
				IDX_IN_MASK: begin
					in_mask <= 8'(merge({24'h0, in_mask},
						i_avs_writedata, i_avs_byteenable));
				end
				IDX_LOOP_MASK: begin
					loop_mask <= 8'(merge({24'h0, loop_mask},
						i_avs_writedata, i_avs_byteenable));
				end
				IDX_SET_THR: begin
					set_thr <= 16'(merge({16'h0, set_thr},
						i_avs_writedata, i_avs_byteenable));
				end
				IDX_CLR_THR: begin
					clr_thr <= 16'(merge({16'h0, clr_thr},
						i_avs_writedata, i_avs_byteenable));
				end
				IDX_TIMER_EN: begin
					timer_en <= 4'(merge({28'h0, timer_en},
						i_avs_writedata, i_avs_byteenable));
				end
				IDX_FAST_EN: begin
					fast_en <= 4'(merge({28'h0, fast_en},
						i_avs_writedata, i_avs_byteenable));
				end
				default: begin
					// Delay words sit here so the case items stay constant.
					for (int l = 0; l < NUM_LOOPS; l++) begin
						if (idx == IDX_DELAY0 + IDX_W'(l)) begin
							clr_delay[l] <= DELAY_W'(merge(
								{3'h0, clr_delay[l]},
								i_avs_writedata, i_avs_byteenable));
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Per-loop lock-loss monitors
	// ----------------------------------------------------------------
	logic [NUM_LOOPS-1:0] lock_loss;

	for (genvar g = 0; g < NUM_LOOPS; g++) begin : g_loop
		logic [MEAS_W-1:0]  ref_cnt;
		logic signed [24:0] diff;
		logic signed [24:0] next_diff;
		logic [24:0]        mag;
		logic [MEAS_W-1:0]  meas;
		logic               meas_vld;
		logic               win_end;
		logic [TIMER_W-1:0] timer;
		logic [TIMER_W-1:0] load;
		logic               timer_run;
		logic [MEAS_W-1:0]  set_lim;
		logic [MEAS_W-1:0]  clr_lim;

		assign set_lim = ppm_tenths(set_thr[g*THR_W +: THR_W]);
		assign clr_lim = ppm_tenths(clr_thr[g*THR_W +: THR_W]);
		assign win_end = i_loop_ref_edge[g]
			&& (ref_cnt == WINDOW_EDGES - 24'h000001);
		// A zero delay still holds off for one cycle, the shortest setting.
		assign load = (clr_delay[g] == DELAY_RST)
			? TIMER_W'(MIN_DELAY_CYC)
			: TIMER_W'(clr_delay[g]) << DELAY_UNIT_SHIFT;

		// Feedback minus input edges over one window of input edges.
		// Edges on both clocks in one cycle cancel, so no count is lost.
		always_comb begin
			next_diff = diff;
			if (i_loop_fb_edge[g] && !i_loop_ref_edge[g]) begin
				next_diff = diff + 25'sd1;
			end else if (i_loop_ref_edge[g] && !i_loop_fb_edge[g]) begin
				next_diff = diff - 25'sd1;
			end
			mag = next_diff[24] ? 25'(-next_diff) : 25'(next_diff);
		end

		always_ff @(posedge i_ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				ref_cnt  <= '0;
				diff     <= '0;
				meas     <= '0;
				meas_vld <= 1'b0;
			end else if (win_end) begin
				ref_cnt  <= '0;
				diff     <= '0;
				meas     <= mag[24] ? '1 : mag[MEAS_W-1:0];
				meas_vld <= 1'b1;
			end else begin
				if (i_loop_ref_edge[g]) begin
					ref_cnt <= ref_cnt + 24'h000001;
				end
				diff     <= next_diff;
				meas_vld <= 1'b0;
			end
		end

		// A window that fails the clear test stops the hold-off; the next passing window reloads it.
		// The count pauses for one cycle whenever a window result arrives.
		always_ff @(posedge i_ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				lock_loss[g] <= 1'b0;
				timer        <= '0;
				timer_run    <= 1'b0;
			end else if (meas_vld) begin
				if (meas > set_lim) begin
					lock_loss[g] <= 1'b1;
					timer_run    <= 1'b0;
				end else if (lock_loss[g] && meas <= clr_lim) begin
					if (!timer_en[g]) begin
						lock_loss[g] <= 1'b0;
					end else if (!timer_run) begin
						timer_run <= 1'b1;
						timer     <= load;
					end
				end else begin
					timer_run <= 1'b0;
				end
			end else if (timer_run) begin
				if (timer <= TIMER_W'(1)) begin
					lock_loss[g] <= 1'b0;
					timer_run    <= 1'b0;
				end else begin
					timer <= timer - TIMER_W'(1);
				end
			end
		end
	end

	assign o_loop_unlocked_pin = lock_loss;

	// Fast acquisition trails the indicator by one cycle to stay registered.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_fast_acquire <= '0;
		end else begin
			o_fast_acquire <= lock_loss & fast_en;
		end
	end

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------
	logic       ref_sticky;
	logic [7:0] in_sticky;
	logic [7:0] loop_sticky;
	logic [7:0] in_live;
	logic [7:0] loop_live;

	assign in_live   = {i_freq_out_of_range, i_signal_missing};
	assign loop_live = {i_loop_holdover, lock_loss};

	// A live alarm wins over a clear in the same cycle.
	// Only bits written with zero on an enabled byte lane may clear.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_sticky  <= 1'b0;
			in_sticky   <= 8'h00;
			loop_sticky <= 8'h00;
		end else begin
			if (wr_fire && idx == IDX_REF_STICKY
					&& zero_wr[REF_BIT] && !i_crystal_missing) begin
				ref_sticky <= 1'b0;
			end else if (i_crystal_missing) begin
				ref_sticky <= 1'b1;
			end
			if (wr_fire && idx == IDX_IN_STICKY) begin
				in_sticky <= (in_sticky & ~(zero_wr[7:0] & ~in_live))
					| in_live;
			end else begin
				in_sticky <= in_sticky | in_live;
			end
			if (wr_fire && idx == IDX_LOOP_STICKY) begin
				loop_sticky <= (loop_sticky
					& ~(zero_wr[7:0] & ~loop_live))
					| loop_live;
			end else begin
				loop_sticky <= loop_sticky | loop_live;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_irq_n_pin <= 1'b1;
		end else begin
			// Low while any unmasked flag stands, high once all clear.
			o_irq_n_pin <= ~(|(in_sticky & ~in_mask)
				| |(loop_sticky & ~loop_mask)
				| (ref_sticky & ~ref_mask));
		end
	end

	// ----------------------------------------------------------------
	// Read path and wait states
	// ----------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h00000000;
		unique case (idx)
			IDX_REF_LIVE:    next_rdata[REF_BIT] = i_crystal_missing;
			IDX_IN_LIVE:     next_rdata[7:0] = in_live;
			IDX_LOOP_LIVE:   next_rdata[7:0] = loop_live;
			IDX_REF_STICKY:  next_rdata[REF_BIT] = ref_sticky;
			IDX_IN_STICKY:   next_rdata[7:0] = in_sticky;
			IDX_LOOP_STICKY: next_rdata[7:0] = loop_sticky;
			IDX_REF_MASK:    next_rdata[REF_BIT] = ref_mask;
			IDX_IN_MASK:     next_rdata[7:0] = in_mask;
			IDX_LOOP_MASK:   next_rdata[7:0] = loop_mask;
			IDX_SET_THR:     next_rdata[15:0] = set_thr;
			IDX_CLR_THR:     next_rdata[15:0] = clr_thr;
			IDX_TIMER_EN:    next_rdata[3:0] = timer_en;
			IDX_FAST_EN:     next_rdata[3:0] = fast_en;
			default: begin
				for (int l = 0; l < NUM_LOOPS; l++) begin
					if (idx == IDX_DELAY0 + IDX_W'(l)) begin
						next_rdata[DELAY_W-1:0] = clr_delay[l];
					end
				end
			end
		endcase
	end

	// Every access takes exactly one wait state.
	// Read data are latched with the answer and hold until the next access.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h00000000;
		end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b0;
			o_avs_readdata    <= next_rdata;
		end else begin
			o_avs_waitrequest <= 1'b1;
		end
	end

endmodule // lock_loss_and_irq_monitor

`default_nettype wire

// [test/lock_loss_and_irq_monitor_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// Port checks
// ------------------------------------
module lock_irq_checker
	import lock_irq_pkg::*;
#(
	parameter logic [MEAS_W-1:0] WINDOW_EDGES = WINDOW_DEFAULT
) (
	// Clock, reset and bus.
	input wire logic                  i_ref_clk,
	input wire logic                  i_arst_n,
	input wire logic [ADDR_W-1:0]     i_avs_address,
	input wire logic                  i_avs_read,
	input wire logic                  i_avs_write,
	input wire logic [31:0]           o_avs_readdata,
	input wire logic                  o_avs_waitrequest,
	// Status.
	input wire logic [NUM_LOOPS-1:0]  i_loop_holdover,
	input wire logic [NUM_LOOPS-1:0]  o_loop_unlocked_pin,
	input wire logic [NUM_LOOPS-1:0]  o_fast_acquire,
	input wire logic [NUM_INPUTS-1:0] i_signal_missing,
	input wire logic [NUM_INPUTS-1:0] i_freq_out_of_range,
	input wire logic                  i_crystal_missing,
	input wire logic                  o_irq_n_pin
);
	logic [IDX_W-1:0] idx;
	logic             done;
	logic             rd_done;
	logic             alarm;
	assign idx = i_avs_address[11:2];
	assign done = !o_avs_waitrequest;
	assign rd_done = done && i_avs_read;
	assign alarm = |{i_signal_missing, i_freq_out_of_range,
		i_crystal_missing, i_loop_holdover, o_loop_unlocked_pin};

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);

	a_one_wait:
	assert property ((i_avs_read || i_avs_write) && !done |=> done)
		else $error("bus answer late");
	a_answer_single:
	assert property (done |=> !done) else $error("bus answer too long");
	a_fast_needs_loss:
	assert property ((o_fast_acquire & ~(o_loop_unlocked_pin
		| $past(o_loop_unlocked_pin))) == '0) else $error("stray fast mode");
	a_irq_fall_cause:
	assert property ($fell(o_irq_n_pin) |-> $past(alarm) || $past(alarm, 2)
		|| $past(i_avs_write && done, 2)) else $error("irq without cause");
	a_irq_rise_cause:
	assert property ($rose(o_irq_n_pin) |-> $past(i_avs_write && done, 2))
		else $error("irq released without write");
	a_status_narrow:
	assert property (rd_done && idx <= IDX_LOOP_MASK
		|-> o_avs_readdata[31:8] == '0) else $error("status upper bits set");
	a_ref_live_read:
	assert property (rd_done && idx == IDX_REF_LIVE
		&& $past(i_crystal_missing) == $past(i_crystal_missing, 2)
		&& $past(i_crystal_missing) == $past(i_crystal_missing, 3)
		|-> o_avs_readdata[REF_BIT] == $past(i_crystal_missing))
		else $error("ref live bit wrong");
	a_pin_matches_live:
	assert property (rd_done && idx == IDX_LOOP_LIVE
		&& $past(o_loop_unlocked_pin) == $past(o_loop_unlocked_pin, 2)
		&& $past(o_loop_unlocked_pin) == $past(o_loop_unlocked_pin, 3)
		|-> o_avs_readdata[3:0] == $past(o_loop_unlocked_pin))
		else $error("unlock pins differ from live bits");
endmodule // lock_irq_checker

bind lock_loss_and_irq_monitor lock_irq_checker #(
	.WINDOW_EDGES(WINDOW_EDGES)
) checker_i (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_loop_holdover(i_loop_holdover),
	.o_loop_unlocked_pin(o_loop_unlocked_pin), .o_fast_acquire(o_fast_acquire),
	.i_signal_missing(i_signal_missing),
	.i_freq_out_of_range(i_freq_out_of_range),
	.i_crystal_missing(i_crystal_missing), .o_irq_n_pin(o_irq_n_pin)
);
`default_nettype wire

// [test/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model
	import lock_irq_pkg::*;
(
	// Bus answer and interrupt.
	input  wire logic              i_clk,
	input  wire logic              i_irq_n,
	input  wire logic [31:0]       i_readdata,
	input  wire logic              i_waitrequest,
	// Bus request.
	output var  logic [ADDR_W-1:0] o_address,
	output var  logic              o_read,
	output var  logic              o_write,
	output var  logic [31:0]       o_writedata,
	output var  logic [3:0]        o_byteenable
);
	initial begin
		o_address = '0;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = '0;
		o_byteenable = 4'hF;
	end

	// The wait is open ended; only the bench watchdog may end it.
	task automatic access(input logic wr, input logic [IDX_W-1:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_clk);
		o_address <= {idx, 2'b00};
		o_write <= wr;
		o_read <= !wr;
		o_writedata <= wd;
		do @(posedge i_clk); while (i_waitrequest !== 1'b0);
		rd = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_writedata <= ~wd;
	endtask

	// Loop settings are loaded once as a prepared profile.
	task automatic configure(input logic [15:0] set_thr, clr_thr,
		input logic [3:0] tmr_en, fast_en, input logic [28:0] delay);
		logic [31:0] rd;
		access(1'b1, IDX_SET_THR, {16'h0, set_thr}, rd);
		access(1'b1, IDX_CLR_THR, {16'h0, clr_thr}, rd);
		access(1'b1, IDX_TIMER_EN, {28'h0, tmr_en}, rd);
		access(1'b1, IDX_FAST_EN, {28'h0, fast_en}, rd);
		for (int n = 0; n < NUM_LOOPS; n++)
			access(1'b1, IDX_W'(IDX_DELAY0 + n), {3'h0, delay}, rd);
	endtask

	// Service: write back the complement so only raised flags get a zero.
	task automatic isr();
		logic [31:0] rd;
		if (i_irq_n !== 1'b0) return;
		for (int k = 0; k < 3; k++) begin
			access(1'b0, IDX_W'(IDX_REF_STICKY + k), 32'h0, rd);
			access(1'b1, IDX_W'(IDX_REF_STICKY + k), ~rd, rd);
		end
	endtask
endmodule // host_model
`default_nettype wire

// [test/lock_loss_and_irq_monitor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lock_loss_and_irq_monitor_tb;
	import lock_irq_pkg::*;
	localparam logic [IDX_W-1:0] MSK_IDX [3] = '{IDX_REF_MASK, IDX_IN_MASK,
		IDX_LOOP_MASK};
	localparam logic [IDX_W-1:0] RST_IDX [12] = '{10'h011, 10'h012, 10'h013,
		10'h017, 10'h018, 10'h019, 10'h09E, 10'h0A0, 10'h0A2, 10'h0A4,
		10'h0A7, 10'h0A8};
	localparam logic [7:0] VALID [3] = '{8'h02, 8'hFF, 8'hFF};
	logic              clk;
	logic              arst_n;
	logic [ADDR_W-1:0] address;
	logic              rd_req;
	logic              wr_req;
	logic [31:0]       wdata;
	logic [3:0]        be;
	logic [31:0]       rdata;
	logic              wait_req;
	logic [3:0]        hold;
	logic [3:0]        unlocked;
	logic [3:0]        fast;
	logic [3:0]        missing;
	logic [3:0]        off_freq;
	logic              xtal;
	logic              irq_n;
	logic [3:0]        speed_up;
	logic              phase;
	logic [31:0]       lfsr;
	logic [31:0]       d;
	logic [7:0]        stk [3];
	logic [7:0]        msk [3];
	int                fail_count;
	int                compares;

	lock_loss_and_irq_monitor #(.WINDOW_EDGES(24'h000010)) dut (
		.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(address),
		.i_avs_read(rd_req), .i_avs_write(wr_req), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .i_loop_ref_edge({4{phase}}),
		.i_loop_fb_edge({4{phase}} | speed_up), .i_loop_holdover(hold),
		.o_loop_unlocked_pin(unlocked), .o_fast_acquire(fast),
		.i_signal_missing(missing), .i_freq_out_of_range(off_freq),
		.i_crystal_missing(xtal), .o_irq_n_pin(irq_n));
	host_model host (.i_clk(clk), .i_irq_n(irq_n), .i_readdata(rdata),
		.i_waitrequest(wait_req), .o_address(address), .o_read(rd_req),
		.o_write(wr_req), .o_writedata(wdata), .o_byteenable(be));

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] e);
		host.access(1'b0, idx, 32'h0, d);
		check($sformatf("register %h", idx), e, d);
	endtask
	task automatic irq_chk();
		logic any;
		any = 1'b0;
		repeat (2) @(posedge clk);
		for (int k = 0; k < 3; k++) any |= |(stk[k] & ~msk[k]);
		check("irq_n", 32'(!any), 32'(irq_n));
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) phase <= ~phase;
	initial begin
		#80000;
		fail_count++;
		test_done();
	end

	initial begin
		{arst_n, xtal, phase, hold, missing, off_freq, speed_up} = '0;
		{stk[0], stk[1], stk[2], msk[0], msk[1], msk[2]} = '0;
		{fail_count, compares} = '0;
		lfsr = 32'hcff7;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (RST_IDX[i]) rd_chk(RST_IDX[i], 32'h0);
		host.access(1'b1, 10'h3FF, 32'hFFFFFFFF, d);
		rd_chk(10'h3FF, 32'h0);
		host.access(1'b1, IDX_LOOP_LIVE, 32'hFF, d);
		rd_chk(IDX_LOOP_LIVE, 32'h0);
		$display("test reset_map done");
		for (int it = 0; it < 6; it++) begin
			lfsr = lfsr_next(lfsr);
			for (int k = 0; k < 3; k++) begin
				host.access(1'b1, MSK_IDX[k], 32'(lfsr[8*k +: 8]), d);
				msk[k] = lfsr[8*k +: 8] & VALID[k];
				rd_chk(MSK_IDX[k], 32'(msk[k]));
			end
			lfsr = lfsr_next(lfsr);
			@(posedge clk);
			{hold, xtal, off_freq, missing} <= lfsr[12:0];
			stk[0] |= {6'h0, lfsr[8], 1'b0};
			stk[1] |= lfsr[7:0];
			stk[2] |= {lfsr[12:9], 4'h0};
			repeat (2) @(posedge clk);
			rd_chk(IDX_IN_LIVE, 32'(lfsr[7:0]));
			rd_chk(IDX_REF_LIVE, 32'({lfsr[8], 1'b0}));
			rd_chk(IDX_LOOP_LIVE, 32'({lfsr[12:9], 4'h0}));
			{hold, xtal, off_freq, missing} <= '0;
			repeat (3) @(posedge clk);
			irq_chk();
			lfsr = lfsr_next(lfsr);
			for (int k = 0; k < 3; k++) begin
				rd_chk(IDX_W'(IDX_REF_STICKY + k), 32'(stk[k]));
				host.access(1'b1, IDX_W'(IDX_REF_STICKY + k), lfsr, d);
				stk[k] &= lfsr[7:0];
				rd_chk(IDX_W'(IDX_REF_STICKY + k), 32'(stk[k]));
			end
			irq_chk();
		end
		$display("test random_flags done");
		host.access(1'b1, IDX_IN_MASK, 32'h0, d);
		msk[1] = 8'h00;
		missing <= 4'h1;
		stk[1] |= 8'h01;
		repeat (2) @(posedge clk);
		host.access(1'b1, IDX_IN_STICKY, 32'h0, d);
		stk[1] = 8'h01;
		rd_chk(IDX_IN_STICKY, 32'h1);
		irq_chk();
		missing <= '0;
		repeat (2) @(posedge clk);
		host.isr();
		{stk[0], stk[1], stk[2]} = '0;
		irq_chk();
		$display("test clear_while_live done");
		for (int k = 0; k < 3; k++) host.access(1'b1, MSK_IDX[k], 32'h0, d);
		{msk[0], msk[1], msk[2]} = '0;
		host.configure(16'h1111, 16'h0000, 4'h4, 4'hF, 29'h1);
		rd_chk(IDX_SET_THR, 32'h1111);
		rd_chk(IDX_W'(IDX_DELAY0 + 2), 32'h1);
		speed_up <= 4'b0110;
		repeat (100) @(posedge clk);
		check("unlocked", 32'h6, 32'(unlocked));
		check("fast", 32'h6, 32'(fast));
		stk[2] = 8'h06;
		rd_chk(IDX_LOOP_LIVE, 32'h6);
		irq_chk();
		speed_up <= '0;
		repeat (80) @(posedge clk);
		check("unlocked", 32'h4, 32'(unlocked));
		repeat (300) @(posedge clk);
		check("unlocked", 32'h0, 32'(unlocked));
		rd_chk(IDX_LOOP_STICKY, 32'h6);
		host.isr();
		stk[2] = 8'h00;
		irq_chk();
		$display("test lock_loss done");
		test_done();
	end
endmodule // lock_loss_and_irq_monitor_tb
`default_nettype wire
